// >>> core/itam_target_addr_match.sv
// Top of the I2C target address match front end: bus watcher, address
// registers and acknowledge of the first byte.
// Assumes raw SCL and SDA pin levels and an open-drain SDA resolved outside.
`timescale 1ns/1ps
`default_nettype none
module itam_target_addr_match import itam_pkg::*; #(
	parameter logic [BYTE_W-1:0] GRP_DEFAULT = 8'hd4 // Arbitrary class value
) (
	input wire logic i_clk, // Device clock, 40 MHz
	input wire logic i_reset, // Synchronous reset, active high
	input wire logic [STRAP_W-1:0] i_addr_strap_low, // Low strap level
	input wire logic [STRAP_W-1:0] i_addr_strap_mid, // Middle strap level
	input wire logic [STRAP_W-1:0] i_addr_strap_high, // High strap level
	input wire logic i_scl, // SCL pin level
	input wire logic i_sda, // SDA pin level
	output logic o_sda_out, // SDA drive value, always low
	output logic o_sda_oe_n, // SDA output enable, low drives
	input wire logic i_bcast_wr, // Broadcast address write strobe
	input wire logic [GRP_CNT-1:0] i_grp_wr, // Group address write strobes
	input wire logic [BYTE_W-1:0] i_addr_wdata, // Address write data
	input wire logic i_en_wr, // Enable write strobe
	input wire logic [3:0] i_en_wdata, // Enables: bit0 broadcast, 1..3 groups
	output logic [BYTE_W-1:0] o_bcast_addr, // Broadcast address
	output logic [BYTE_W-1:0] o_grp_addr_first, // First group address
	output logic [BYTE_W-1:0] o_grp_addr_second, // Second group address
	output logic [BYTE_W-1:0] o_grp_addr_third, // Third group address
	output logic [3:0] o_addr_en, // Address enables
	output logic [ADDR_W-1:0] o_own_addr, // Strap address
	output logic o_own_valid, // Strap address captured
	output logic o_addr_ack, // Pulse: address acknowledged
	output logic [HIT_W-1:0] o_hit, // Matched sources, own/bcast/groups
	output logic o_read, // Direction of the selected transfer
	output logic o_selected // Level: transfer addressed to us
);
	function automatic logic addr_eq(input logic [BYTE_W-1:0] a, input logic [BYTE_W-1:0] b);
		addr_eq = (a[BYTE_W-1:1] == b[BYTE_W-1:1]);
	endfunction : addr_eq

	itam_addr_if addr_bus ();
	itam_strap_decode u_strap (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_addr_strap_low(i_addr_strap_low),
		.i_addr_strap_mid(i_addr_strap_mid),
		.i_addr_strap_high(i_addr_strap_high),
		.addr_bus(addr_bus)
	);

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_d_r;
	logic sda_d_r;
	itam_state_e state_r;
	logic [BYTE_W-1:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic [BYTE_W-1:0] bcast_r;
	logic [BYTE_W-1:0] grp_r [GRP_CNT];
	logic [3:0] en_r;
	logic [ADDR_W-1:0] own_r;
	logic own_valid_r;
	logic sda_oe_n_r;
	logic ack_r;
	logic [HIT_W-1:0] hit_r;
	logic read_r;
	logic sel_r;
	logic sda_out_r;
	wire [HIT_W-1:0] hit_w;

	wire scl_w = scl_sync_r[1];
	wire sda_w = sda_sync_r[1];
	wire scl_rise = scl_w & ~scl_d_r;
	wire scl_fall = ~scl_w & scl_d_r;
	wire start_det = scl_w & scl_d_r & sda_d_r & ~sda_w;
	wire stop_det = scl_w & scl_d_r & ~sda_d_r & sda_w;
	wire ack_start = (state_r == ST_ADDR) && (bit_cnt_r == BITS_PER_BYTE) && scl_fall;
	wire any_hit = |hit_w;

	// Match sources
	assign hit_w[HIT_OWN] = own_valid_r && addr_eq(shift_r, {own_r, 1'b0});
	assign hit_w[HIT_BCAST] = en_r[EN_BCAST] && addr_eq(shift_r, bcast_r);
	genvar g;
	generate
		for (g = 0; g < GRP_CNT; g++) begin : g_grp
			assign hit_w[HIT_GRP0+g] = en_r[EN_GRP0+g] && addr_eq(shift_r, grp_r[g]);
			always_ff @(posedge i_clk) begin
				if (i_reset) grp_r[g] <= GRP_DEFAULT;
				else if (i_grp_wr[g]) grp_r[g] <= i_addr_wdata;
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		scl_sync_r <= {scl_sync_r[0], i_scl};
		sda_sync_r <= {sda_sync_r[0], i_sda};
		scl_d_r <= scl_w;
		sda_d_r <= sda_w;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			bcast_r <= BCAST_RST;
			en_r <= ADDR_EN_RST;
			own_r <= 7'h00;
			own_valid_r <= 1'b0;
		end else begin
			if (i_bcast_wr) bcast_r <= i_addr_wdata;
			if (i_en_wr) en_r <= i_en_wdata;
			own_r <= addr_bus.own_addr;
			own_valid_r <= addr_bus.own_valid;
		end
	end

	// Address byte reception and acknowledge
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			sda_oe_n_r <= 1'b1;
			ack_r <= 1'b0;
			hit_r <= 5'h00;
			read_r <= 1'b0;
			sel_r <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			ack_r <= 1'b0;
			if (start_det) begin
				state_r <= ST_ADDR;
				bit_cnt_r <= 4'h0;
				sda_oe_n_r <= 1'b1;
				sel_r <= 1'b0;
			end else if (stop_det) begin
				state_r <= ST_IDLE;
				sda_oe_n_r <= 1'b1;
				sel_r <= 1'b0;
			end else begin
				case (state_r)
					ST_ADDR: begin
						if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
							shift_r <= {shift_r[BYTE_W-2:0], sda_w};
							bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
						end
						if (ack_start) begin
							hit_r <= hit_w;
							read_r <= shift_r[0];
							if (any_hit) begin
								state_r <= ST_ACK;
								sda_oe_n_r <= 1'b0;
								ack_r <= 1'b1;
								sel_r <= 1'b1;
							end else begin
								state_r <= ST_IGNORE;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							state_r <= ST_SELECT;
							sda_oe_n_r <= 1'b1;
						end
					end
					ST_SELECT: state_r <= ST_SELECT;
					ST_IGNORE: state_r <= ST_IGNORE;
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	assign o_sda_out = sda_out_r;
	assign o_sda_oe_n = sda_oe_n_r;
	assign o_bcast_addr = bcast_r;
	assign o_grp_addr_first = grp_r[0];
	assign o_grp_addr_second = grp_r[1];
	assign o_grp_addr_third = grp_r[2];
	assign o_addr_en = en_r;
	assign o_own_addr = own_r;
	assign o_own_valid = own_valid_r;
	assign o_addr_ack = ack_r;
	assign o_hit = hit_r;
	assign o_read = read_r;
	assign o_selected = sel_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	own_match_a: assert property (ack_start && hit_w[HIT_OWN] |-> shift_r[7:1] == own_r)
		else $error("own hit without equal address");
	dir_bit_a: assert property (ack_start && any_hit |=> o_read == $past(shift_r[0]) && o_addr_ack)
		else $error("direction bit not reported");
	bcast_reset_a: assert property ($past(i_reset) && !i_bcast_wr |-> o_bcast_addr == BCAST_RST)
		else $error("broadcast address reset wrong");
	bcast_enable_a: assert property ($past(i_reset) && !i_en_wr |-> o_addr_en[EN_BCAST])
		else $error("broadcast not enabled after reset");
	grp_write_a: assert property (i_grp_wr[1] |=> o_grp_addr_second == $past(i_addr_wdata))
		else $error("group address write lost");
	grp_reset_a: assert property ($past(i_reset) && i_grp_wr == 3'h0 |-> o_grp_addr_first == GRP_DEFAULT
		&& o_grp_addr_second == GRP_DEFAULT && o_grp_addr_third == GRP_DEFAULT)
		else $error("group address reset wrong");
	grp_enable_a: assert property ($past(i_reset) && !i_en_wr |-> o_addr_en[3:1] == 3'h1)
		else $error("group enables reset wrong");
	no_match_a: assert property (ack_start && !any_hit && !start_det && !stop_det
		|=> o_sda_oe_n && !o_selected && !o_addr_ack)
		else $error("unmatched address acknowledged");
	ack_drive_a: assert property (ack_start && any_hit && !start_det && !stop_det
		|=> !o_sda_oe_n && o_selected)
		else $error("matched address not acknowledged");
	ack_release_a: assert property (state_r == ST_ACK && scl_fall && !start_det && !stop_det
		|=> o_sda_oe_n && o_selected)
		else $error("acknowledge not released after ninth clock");
	ignore_quiet_a: assert property (state_r == ST_IGNORE |-> o_sda_oe_n && !o_selected)
		else $error("ignored transfer drives the bus");
	stop_clear_a: assert property (stop_det |=> !o_selected && o_sda_oe_n)
		else $error("selection kept after stop");
	hit_clear_a: assert property (ack_start && !any_hit |=> o_hit == 5'h00)
		else $error("hit recorded for unmatched address");

	own_ack_c: cover property (ack_start && hit_w[HIT_OWN]);
	bcast_ack_c: cover property (ack_start && hit_w[HIT_BCAST]);
	grp_ack_c: cover property (ack_start && hit_w[HIT_GRP0]);
	read_ack_c: cover property (ack_start && any_hit && shift_r[0]);
	ignore_c: cover property (ack_start && !any_hit);
endmodule : itam_target_addr_match
`default_nettype wire

// >>> core/itam_pkg.sv
// Constants and types for the I2C target address match front end.
// Assumes a single device clock and a synchronous active-high reset.
// Summary of operation
// - The own target address is recognised only when the received seven bits equal the address selected by the three five-level straps, one of 125.
// - The low bit of the address byte gives the direction, one for a read and zero for a write, and the device reports it for the selected operation.
// - The broadcast address register resets to e0 with the direction bit ignored, and can be rewritten but is not kept over power loss.
// - After reset the broadcast address is enabled, so e0 for writes and e1 for reads are acknowledged at once.
// - Three group address registers can be rewritten and are compared with incoming address bytes while enabled.
// - All three group address registers reset to the same class default, direction bit ignored.
// - After reset only the first group address is enabled; the second and third are not acknowledged.
package itam_pkg;
	localparam int STRAP_W = 3;
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int GRP_CNT = 3;
	localparam int HIT_W = 5;
	// Strap level codes
	localparam logic [STRAP_W-1:0] LVL_GND = 3'h0;
	localparam logic [STRAP_W-1:0] LVL_PD = 3'h1;
	localparam logic [STRAP_W-1:0] LVL_FLT = 3'h2;
	localparam logic [STRAP_W-1:0] LVL_PU = 3'h3;
	localparam logic [STRAP_W-1:0] LVL_VDD = 3'h4;
	localparam logic [ADDR_W-1:0] LVL_BASE = 7'h05;
	localparam logic [ADDR_W-1:0] LVL_BASE_SQ = 7'h19;
	localparam logic [ADDR_W-1:0] OWN_ADDR_FIRST = 7'h01;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	// Address registers
	localparam logic [BYTE_W-1:0] BCAST_RST = 8'he0;
	localparam logic [3:0] ADDR_EN_RST = 4'h3;
	localparam int EN_BCAST = 0;
	localparam int EN_GRP0 = 1;
	localparam int HIT_OWN = 0;
	localparam int HIT_BCAST = 1;
	localparam int HIT_GRP0 = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_SELECT, ST_IGNORE} itam_state_e;
endpackage : itam_pkg

// >>> core/itam_addr_if.sv
// Carrier for the decoded own address between strap decoder and matcher.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface itam_addr_if;
	logic [6:0] own_addr;
	logic own_valid;
	modport prod (output own_addr, output own_valid);
	modport cons (input own_addr, input own_valid);
endinterface : itam_addr_if
`default_nettype wire

// >>> core/itam_strap_decode.sv
// Strap synchroniser and five-level decoder giving the own target address.
// Assumes strap level codes arrive asynchronously and hold still after power-up.
`timescale 1ns/1ps
`default_nettype none
module itam_strap_decode import itam_pkg::*; (
	input wire logic i_clk, // Device clock
	input wire logic i_reset, // Synchronous reset
	input wire logic [STRAP_W-1:0] i_addr_strap_low, // Low strap level
	input wire logic [STRAP_W-1:0] i_addr_strap_mid, // Middle strap level
	input wire logic [STRAP_W-1:0] i_addr_strap_high, // High strap level
	itam_addr_if.prod addr_bus // Decoded own address
);
	// Out-of-range codes read as floating
	function automatic logic [ADDR_W-1:0] lvl_val(input logic [STRAP_W-1:0] lvl);
		lvl_val = (lvl > LVL_VDD) ? {4'h0, LVL_FLT} : {4'h0, lvl};
	endfunction : lvl_val

	logic [STRAP_W-1:0] sync1_r [3];
	logic [STRAP_W-1:0] sync2_r [3];
	logic [STRAP_W-1:0] strap_in [3];
	logic [1:0] settle_r;
	logic [ADDR_W-1:0] own_r;
	logic valid_r;
	wire [ADDR_W-1:0] addr_nxt;

	assign strap_in[0] = i_addr_strap_low;
	assign strap_in[1] = i_addr_strap_mid;
	assign strap_in[2] = i_addr_strap_high;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge i_clk) begin
				sync1_r[g] <= strap_in[g];
				sync2_r[g] <= sync1_r[g];
			end
		end
	endgenerate

	// Index of the strap combination plus one
	assign addr_nxt = 7'(lvl_val(sync2_r[2]) * LVL_BASE_SQ + lvl_val(sync2_r[1]) * LVL_BASE
		+ lvl_val(sync2_r[0]) + OWN_ADDR_FIRST);

	// Captured once, after the synchroniser has filled
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			settle_r <= 2'h0;
			valid_r <= 1'b0;
			own_r <= 7'h00;
		end else if (!valid_r) begin
			settle_r <= 2'(settle_r + 2'h1);
			if (settle_r == STRAP_SETTLE) begin
				valid_r <= 1'b1;
				own_r <= addr_nxt;
			end
		end
	end

	assign addr_bus.own_addr = own_r;
	assign addr_bus.own_valid = valid_r;
endmodule : itam_strap_decode
`default_nettype wire

// >>> dv/itam_i2c_ctrl_model.sv
// Behavioural I2C bus controller that addresses the target front end.
// Assumes a pull-up on both lines: a released line reads one.
`timescale 1ns/1ps
`default_nettype none
module itam_i2c_ctrl_model #(
	parameter int PHASE = 6 // Clocks per SCL phase
) (
	input wire logic i_clk, // Device clock
	input wire logic i_sda, // Resolved SDA line
	output logic o_scl, // SCL drive, one releases
	output logic o_sda // SDA drive, one releases
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic ph();
		repeat (PHASE) @(posedge i_clk);
	endtask : ph
	// Start, one byte MSB first, then the ninth clock
	task automatic send_addr(input logic [7:0] b, output logic ack);
		ph();
		o_sda <= 1'b0;
		ph();
		o_scl <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			ph();
			o_sda <= b[i];
			ph();
			o_scl <= 1'b1;
			ph();
			o_scl <= 1'b0;
		end
		ph();
		o_sda <= 1'b1;
		ph();
		o_scl <= 1'b1;
		ph();
		ack = !i_sda;
		o_scl <= 1'b0;
		ph();
	endtask : send_addr
	task automatic stop();
		@(posedge i_clk);
		o_sda <= 1'b0;
		ph();
		o_scl <= 1'b1;
		ph();
		o_sda <= 1'b1;
		ph();
	endtask : stop
endmodule : itam_i2c_ctrl_model
`default_nettype wire

// >>> dv/tb_itam_target_addr_match.sv
// Self-checking bench for the target address match front end.
// Assumes the controller model drives the bus and the straps stay still.
`timescale 1ns/1ps
`default_nettype none
module tb_itam_target_addr_match import itam_pkg::*;;
	localparam logic [7:0] GD = 8'hd4;
	logic clk, rst, bw, ew, scl, csda, so, soe_n, ack_p, own_v, sel, rd;
	logic [2:0] sl, sm, sh, gw;
	logic [7:0] wd, ba, g1, g2, g3;
	logic [3:0] ed, en;
	logic [6:0] own;
	logic [4:0] hit;
	int err_count, samples_checked, pulses;
	wire logic sda = csda & (soe_n | so);
	itam_target_addr_match #(.GRP_DEFAULT(GD)) dut (.i_clk(clk), .i_reset(rst),
		.i_addr_strap_low(sl), .i_addr_strap_mid(sm), .i_addr_strap_high(sh), .i_scl(scl),
		.i_sda(sda), .o_sda_out(so), .o_sda_oe_n(soe_n), .i_bcast_wr(bw), .i_grp_wr(gw),
		.i_addr_wdata(wd), .i_en_wr(ew), .i_en_wdata(ed), .o_bcast_addr(ba),
		.o_grp_addr_first(g1), .o_grp_addr_second(g2), .o_grp_addr_third(g3),
		.o_addr_en(en), .o_own_addr(own), .o_own_valid(own_v), .o_addr_ack(ack_p),
		.o_hit(hit), .o_read(rd), .o_selected(sel));
	itam_i2c_ctrl_model ctrl (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(csda));
	always #12.5 clk = ~clk;
	always @(posedge clk) if (ack_p === 1'b1) pulses++;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic do_reset(input logic [2:0] code);
		int n;
		@(posedge clk);
		{sl, sm, sh} <= {code, code, code};
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		n = 0;
		while (own_v !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (own_v !== 1'b1) begin
			chk("own_valid", 8'h01, {7'h0, own_v});
			report_and_stop();
		end
		repeat (4) @(posedge clk);
	endtask : do_reset
	task automatic wr(input logic b, input logic [2:0] g, input logic e, input logic [7:0] d);
		@(posedge clk);
		bw <= b;
		gw <= g;
		ew <= e;
		wd <= d;
		ed <= d[3:0];
		@(posedge clk);
		bw <= 1'b0;
		gw <= 3'h0;
		ew <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic probe(input logic [7:0] b, input logic ea, input logic [4:0] eh);
		logic a;
		int p0;
		p0 = pulses;
		ctrl.send_addr(b, a);
		@(negedge clk);
		chk("ack", {7'h0, ea}, {7'h0, a});
		chk("ack_pulse", {7'h0, ea}, 8'(pulses - p0));
		chk("hit", {3'h0, eh}, {3'h0, hit});
		chk("selected", {7'h0, ea}, {7'h0, sel});
		if (ea) chk("read", {7'h0, b[0]}, {7'h0, rd});
		ctrl.stop();
		@(negedge clk);
		chk("selected_stop", 8'h00, {7'h0, sel});
	endtask : probe
	task automatic sc_defaults(input logic [7:0] own_exp);
		@(negedge clk);
		chk("bcast", BCAST_RST, ba);
		chk("grp1", GD, g1);
		chk("grp2", GD, g2);
		chk("grp3", GD, g3);
		chk("en", 8'h03, {4'h0, en});
		chk("own", own_exp, {1'b0, own});
	endtask : sc_defaults
	task automatic sc_own();
		probe(8'hbc, 1'b1, 5'h01);
		probe(8'hbd, 1'b1, 5'h01);
		probe(8'hbe, 1'b0, 5'h00);
	endtask : sc_own
	task automatic sc_bcast();
		probe(8'he0, 1'b1, 5'h02);
		probe(8'he1, 1'b1, 5'h02);
	endtask : sc_bcast
	task automatic sc_group();
		probe(GD, 1'b1, 5'h04);
		wr(1'b0, 3'h0, 1'b1, 8'h0f);
		probe(GD | 8'h01, 1'b1, 5'h1c);
	endtask : sc_group
	task automatic sc_rewrite();
		wr(1'b1, 3'h0, 1'b0, 8'h30);
		wr(1'b0, 3'h2, 1'b0, 8'h40);
		chk("bcast", 8'h30, ba);
		chk("grp2", 8'h40, g2);
		probe(8'h31, 1'b1, 5'h02);
		probe(8'he0, 1'b0, 5'h00);
		probe(8'h41, 1'b1, 5'h08);
		wr(1'b0, 3'h0, 1'b1, 8'h00);
		probe(8'h30, 1'b0, 5'h00);
		probe(GD, 1'b0, 5'h00);
		probe(8'hbc, 1'b1, 5'h01);
	endtask : sc_rewrite
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{sl, sm, sh} = {LVL_PU, LVL_PU, LVL_PU};
		{bw, ew, gw, wd, ed} = '0;
		do_reset(LVL_PU);
		sc_defaults(8'h5e);
		sc_own();
		sc_bcast();
		sc_group();
		sc_rewrite();
		do_reset(LVL_GND);
		sc_defaults(8'h01);
		probe(8'h03, 1'b1, 5'h01);
		report_and_stop();
	end
endmodule : tb_itam_target_addr_match
`default_nettype wire
